//--- rtl/hsrd_pkg.sv
package hsrd_pkg;

  // i2c target identity and register offsets
  localparam logic [6:0] I2C_TARGET_ADDR = 7'h2c;
  localparam logic [7:0] OFS_TRANSITION = 8'h01;
  localparam logic [7:0] OFS_MODE_SELECT = 8'h03;
  localparam logic [7:0] OFS_STATIC = 8'h0e;
  localparam logic [7:0] OFS_RECEIVE = 8'h25;

  // field positions
  localparam int TRANS_FIELD_HI = 7;
  localparam int TRANS_FIELD_LO = 4;
  localparam int STATIC_FIELD_HI = 3;
  localparam int STATIC_FIELD_LO = 0;
  localparam int CFG_HOLD_BIT = 0;

  // reset values
  localparam logic [7:0] MODE_SELECT_RESET = 8'h01;
  localparam logic [7:0] GAIN_REG_RESET = 8'h00;
  localparam logic [7:0] UNMAPPED_READ = 8'h00;

  // strap decode tables
  localparam logic [3:0] TRANS_LVL0 = 4'h0;
  localparam logic [3:0] TRANS_LVL1 = 4'h3;
  localparam logic [3:0] TRANS_LVL2 = 4'h6;
  localparam logic [3:0] TRANS_LVL3 = 4'ha;
  localparam logic [3:0] STATIC_LVL0 = 4'h0;
  localparam logic [3:0] STATIC_LVL12 = 4'h2;
  localparam logic [3:0] STATIC_LVL3 = 4'h6;
  localparam logic [7:0] RX_LVL_LOW = 8'h00;
  localparam logic [7:0] RX_LVL_MID = 8'h33;
  localparam logic [7:0] RX_LVL_HIGH = 8'h66;

  // timing: i2c enable sample point after leaving shutdown
  localparam int CLK_PERIOD_NS = 5;
  localparam int I2C_SAMPLE_NS = 1000;
  localparam int I2C_SAMPLE_CYC = (I2C_SAMPLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // three-level receive sensitivity strap as resolved by the pad
  typedef enum logic [1:0] {
    HSRD_RX_LOW,
    HSRD_RX_MID,
    HSRD_RX_HIGH
  } hsrd_rx_lvl_t;

  typedef enum logic [2:0] {
    HSRD_SHUTDOWN,
    HSRD_IDLE,
    HSRD_LOW_SPEED,
    HSRD_FULL_SPEED,
    HSRD_HIGH_SPEED,
    HSRD_COMPLIANCE
  } hsrd_mode_t;

endpackage : hsrd_pkg

//--- rtl/hsrd_mode_fsm.sv
`timescale 1ns/10ps
module hsrd_mode_fsm (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic active_low_reset_in,
  input wire logic hold_in,
  input wire logic ls_detect_in,
  input wire logic fs_detect_in,
  input wire logic hs_detect_in,
  input wire logic fixture_detect_in,
  output hsrd_pkg::hsrd_mode_t mode_r,
  output logic connection_detect_r,
  output logic hs_active_r,
  output logic comp_enable_r
);
  import hsrd_pkg::*;

  hsrd_mode_t mode_nxt;
  logic hs_seen_r;
  logic hs_seen_nxt;
  logic connection_detect_nxt;
  logic hs_active_nxt;
  logic comp_enable_nxt;

  // fixture outranks speed; no detect at all means disconnected
  function automatic hsrd_mode_t pick_speed(input logic ls, input logic fs,
                                            input logic hs, input logic fix);
    if (fix) begin
      return HSRD_COMPLIANCE;
    end else if (hs) begin
      return HSRD_HIGH_SPEED;
    end else if (fs) begin
      return HSRD_FULL_SPEED;
    end else if (ls) begin
      return HSRD_LOW_SPEED;
    end
    return HSRD_IDLE;
  endfunction : pick_speed

  always_comb begin
    mode_nxt = mode_r;
    hs_seen_nxt = hs_seen_r;
    if (!rst_n) begin
      mode_nxt = HSRD_SHUTDOWN;
      hs_seen_nxt = 1'b0;
    end else if (!active_low_reset_in) begin
      mode_nxt = HSRD_SHUTDOWN;
      if (mode_r == HSRD_HIGH_SPEED) begin
        hs_seen_nxt = 1'b1;
      end
    end else if (mode_r == HSRD_SHUTDOWN) begin
      mode_nxt = hs_seen_r ? HSRD_COMPLIANCE : HSRD_IDLE;
      hs_seen_nxt = 1'b0;
    end else if (!hold_in) begin
      unique case (mode_r)
        HSRD_IDLE, HSRD_LOW_SPEED, HSRD_FULL_SPEED, HSRD_HIGH_SPEED: begin
          mode_nxt = pick_speed(ls_detect_in, fs_detect_in, hs_detect_in,
                                fixture_detect_in);
        end
        HSRD_COMPLIANCE: begin
          // test mode is left only when both the hs and fixture detects are low
          if (!hs_detect_in && !fixture_detect_in) begin
            mode_nxt = HSRD_IDLE;
          end
        end
        default: begin
          mode_nxt = HSRD_SHUTDOWN;
        end
      endcase
    end
  end

  always_comb begin
    connection_detect_nxt = 1'b0;
    hs_active_nxt = 1'b0;
    comp_enable_nxt = 1'b0;
    unique case (mode_nxt)
      HSRD_LOW_SPEED: connection_detect_nxt = 1'b1;
      HSRD_FULL_SPEED: connection_detect_nxt = 1'b1;
      HSRD_HIGH_SPEED: begin
        connection_detect_nxt = 1'b1;
        hs_active_nxt = 1'b1;
        comp_enable_nxt = 1'b1;
      end
      HSRD_COMPLIANCE: begin
        hs_active_nxt = 1'b1;
        comp_enable_nxt = 1'b1;
      end
      default: begin
        connection_detect_nxt = 1'b0;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    mode_r <= mode_nxt;
    hs_seen_r <= hs_seen_nxt;
    connection_detect_r <= connection_detect_nxt;
    hs_active_r <= hs_active_nxt;
    comp_enable_r <= comp_enable_nxt;
  end

endmodule : hsrd_mode_fsm

//--- rtl/hsrd_top.sv
`timescale 1ns/10ps
// Function
// - low speed: no compensation, detect high
// - full speed: no compensation, detect high
// - high speed: compensation from gain settings
// - high speed boost: both indications high
// - fixture: eye test, detect low, hs high
// - reset pulse in high speed: compliance mode
// - reset pin low: shutdown, both outputs low
// - standard mode i2c target for configuration
// - i2c enabled if lines high after shutdown
// - answer at seven-bit address 0x2c
// - charge port controller on when pin low
// - transition field loads mapped boost strap
// - static field loads mapped boost strap
// - receive field loads mapped sensitivity strap
// - hold bit resets to configuration mode
// - boost strap sampled only at reset release
// - boost strap gives four levels
// - sensitivity strap gives three levels
module hsrd_top (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic active_low_reset_in,
  input wire logic [1:0] boost_strap_in,
  input hsrd_pkg::hsrd_rx_lvl_t rx_gain_strap_pin,
  input wire logic charge_port_enable_n,
  input wire logic ls_detect_in,
  input wire logic fs_detect_in,
  input wire logic hs_detect_in,
  input wire logic fixture_detect_in,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  output logic connection_detect_out,
  output logic hs_active_out,
  output logic comp_enable_out,
  output logic [3:0] transition_gain_out,
  output logic [3:0] static_gain_out,
  output logic [7:0] rx_gain_out,
  output logic charge_port_on_out,
  output logic i2c_enabled_out
);
  import hsrd_pkg::*;

  typedef enum logic [2:0] {
    HSRD_I2C_IDLE,
    HSRD_I2C_ADDR,
    HSRD_I2C_ADDR_ACK,
    HSRD_I2C_WRITE,
    HSRD_I2C_WRITE_ACK,
    HSRD_I2C_READ,
    HSRD_I2C_READ_ACK
  } hsrd_i2c_st_t;

  localparam logic [7:0] SAMPLE_LOAD = 8'(I2C_SAMPLE_CYC);

  // register bank
  logic [7:0] transition_gain_setting_r;
  logic [7:0] transition_gain_setting_nxt;
  logic [7:0] mode_select_r;
  logic [7:0] mode_select_nxt;
  logic [7:0] static_gain_setting_r;
  logic [7:0] static_gain_setting_nxt;
  logic [7:0] receive_gain_setting_r;
  logic [7:0] receive_gain_setting_nxt;
  logic load_pend_r;
  logic load_pend_nxt;
  logic i2c_en_r;
  logic i2c_en_nxt;
  logic [7:0] sample_cnt_r;
  logic [7:0] sample_cnt_nxt;
  logic charge_port_r;
  logic charge_port_nxt;

  // i2c engine
  hsrd_i2c_st_t i2c_st_r;
  hsrd_i2c_st_t i2c_st_nxt;
  logic [3:0] bit_cnt_r;
  logic [3:0] bit_cnt_nxt;
  logic [7:0] shift_r;
  logic [7:0] shift_nxt;
  logic [7:0] offset_r;
  logic [7:0] offset_nxt;
  logic offset_phase_r;
  logic offset_phase_nxt;
  logic read_dir_r;
  logic read_dir_nxt;
  logic sda_oe_r;
  logic sda_oe_nxt;
  logic sda_out_r;
  logic scl_q_r;
  logic sda_q_r;
  logic scl_rise;
  logic scl_fall;
  logic bus_start;
  logic bus_stop;
  logic wr_stb;
  logic [7:0] rd_data;
  logic hold_req;

  function automatic logic [3:0] map_transition(input logic [1:0] lvl);
    unique case (lvl)
      2'h0: return TRANS_LVL0;
      2'h1: return TRANS_LVL1;
      2'h2: return TRANS_LVL2;
      default: return TRANS_LVL3;
    endcase
  endfunction : map_transition

  function automatic logic [3:0] map_static(input logic [1:0] lvl);
    unique case (lvl)
      2'h0: return STATIC_LVL0;
      2'h1, 2'h2: return STATIC_LVL12;
      default: return STATIC_LVL3;
    endcase
  endfunction : map_static

  function automatic logic [7:0] map_receive(input hsrd_rx_lvl_t lvl);
    case (lvl)
      HSRD_RX_LOW: return RX_LVL_LOW;
      HSRD_RX_MID: return RX_LVL_MID;
      HSRD_RX_HIGH: return RX_LVL_HIGH;
      default: return RX_LVL_MID;
    endcase
  endfunction : map_receive

  always_comb begin
    unique case (offset_r)
      OFS_TRANSITION: rd_data = transition_gain_setting_r;
      OFS_MODE_SELECT: rd_data = mode_select_r;
      OFS_STATIC: rd_data = static_gain_setting_r;
      OFS_RECEIVE: rd_data = receive_gain_setting_r;
      default: rd_data = UNMAPPED_READ;
    endcase
  end

  always_comb begin
    transition_gain_setting_nxt = transition_gain_setting_r;
    mode_select_nxt = mode_select_r;
    static_gain_setting_nxt = static_gain_setting_r;
    receive_gain_setting_nxt = receive_gain_setting_r;
    load_pend_nxt = load_pend_r;
    i2c_en_nxt = i2c_en_r;
    sample_cnt_nxt = sample_cnt_r;
    charge_port_nxt = ~charge_port_enable_n;
    if (!rst_n) begin
      transition_gain_setting_nxt = GAIN_REG_RESET;
      mode_select_nxt = MODE_SELECT_RESET;
      static_gain_setting_nxt = GAIN_REG_RESET;
      receive_gain_setting_nxt = GAIN_REG_RESET;
      load_pend_nxt = 1'b1;
      i2c_en_nxt = 1'b0;
      sample_cnt_nxt = 8'h00;
      charge_port_nxt = 1'b0;
    end else if (!active_low_reset_in || load_pend_r) begin
      transition_gain_setting_nxt[TRANS_FIELD_HI:TRANS_FIELD_LO] =
        map_transition(boost_strap_in);
      static_gain_setting_nxt[STATIC_FIELD_HI:STATIC_FIELD_LO] =
        map_static(boost_strap_in);
      receive_gain_setting_nxt = map_receive(rx_gain_strap_pin);
      mode_select_nxt = MODE_SELECT_RESET;
      load_pend_nxt = 1'b0;
      i2c_en_nxt = 1'b0;
      sample_cnt_nxt = SAMPLE_LOAD;
    end else begin
      if (sample_cnt_r != 8'h00) begin
        sample_cnt_nxt = sample_cnt_r - 8'h01;
        if (sample_cnt_r == 8'h01) begin
          i2c_en_nxt = scl_in & sda_in;
        end
      end
      if (wr_stb) begin
        // unlisted offsets swallow the write and read back as zero
        unique case (offset_r)
          OFS_TRANSITION: transition_gain_setting_nxt = shift_r;
          OFS_MODE_SELECT: mode_select_nxt = shift_r;
          OFS_STATIC: static_gain_setting_nxt = shift_r;
          OFS_RECEIVE: receive_gain_setting_nxt = shift_r;
          default: begin
            mode_select_nxt = mode_select_r;
          end
        endcase
      end
    end
  end

  always_ff @(posedge clk) begin
    transition_gain_setting_r <= transition_gain_setting_nxt;
    mode_select_r <= mode_select_nxt;
    static_gain_setting_r <= static_gain_setting_nxt;
    receive_gain_setting_r <= receive_gain_setting_nxt;
    load_pend_r <= load_pend_nxt;
    i2c_en_r <= i2c_en_nxt;
    sample_cnt_r <= sample_cnt_nxt;
    charge_port_r <= charge_port_nxt;
  end

  assign scl_rise = scl_in & ~scl_q_r;
  assign scl_fall = ~scl_in & scl_q_r;
  assign bus_start = scl_in & scl_q_r & sda_q_r & ~sda_in;
  assign bus_stop = scl_in & scl_q_r & ~sda_q_r & sda_in;

  always_comb begin
    i2c_st_nxt = i2c_st_r;
    bit_cnt_nxt = bit_cnt_r;
    shift_nxt = shift_r;
    offset_nxt = offset_r;
    offset_phase_nxt = offset_phase_r;
    read_dir_nxt = read_dir_r;
    sda_oe_nxt = sda_oe_r;
    wr_stb = 1'b0;
    if (!rst_n || !i2c_en_r) begin
      i2c_st_nxt = HSRD_I2C_IDLE;
      bit_cnt_nxt = 4'h0;
      shift_nxt = 8'h00;
      offset_phase_nxt = 1'b1;
      read_dir_nxt = 1'b0;
      sda_oe_nxt = 1'b0;
      if (!rst_n) begin
        offset_nxt = 8'h00;
      end
    end else if (bus_start) begin
      i2c_st_nxt = HSRD_I2C_ADDR;
      bit_cnt_nxt = 4'h0;
      offset_phase_nxt = 1'b1;
      sda_oe_nxt = 1'b0;
    end else if (bus_stop) begin
      i2c_st_nxt = HSRD_I2C_IDLE;
      sda_oe_nxt = 1'b0;
    end else if (scl_rise) begin
      unique case (i2c_st_r)
        HSRD_I2C_ADDR, HSRD_I2C_WRITE: begin
          shift_nxt = {shift_r[6:0], sda_in};
          bit_cnt_nxt = bit_cnt_r + 4'h1;
        end
        HSRD_I2C_READ_ACK: begin
          // a nack ends the read; wait for stop or repeated start
          if (sda_in) begin
            i2c_st_nxt = HSRD_I2C_IDLE;
          end
        end
        default: begin
          bit_cnt_nxt = bit_cnt_r;
        end
      endcase
    end else if (scl_fall) begin
      unique case (i2c_st_r)
        HSRD_I2C_ADDR: begin
          if (bit_cnt_r == 4'h8) begin
            if (shift_r[7:1] == I2C_TARGET_ADDR) begin
              read_dir_nxt = shift_r[0];
              sda_oe_nxt = 1'b1;
              i2c_st_nxt = HSRD_I2C_ADDR_ACK;
            end else begin
              i2c_st_nxt = HSRD_I2C_IDLE;
            end
          end
        end
        HSRD_I2C_ADDR_ACK: begin
          bit_cnt_nxt = 4'h0;
          if (read_dir_r) begin
            shift_nxt = rd_data;
            sda_oe_nxt = ~rd_data[7];
            i2c_st_nxt = HSRD_I2C_READ;
          end else begin
            sda_oe_nxt = 1'b0;
            i2c_st_nxt = HSRD_I2C_WRITE;
          end
        end
        HSRD_I2C_WRITE: begin
          if (bit_cnt_r == 4'h8) begin
            sda_oe_nxt = 1'b1;
            i2c_st_nxt = HSRD_I2C_WRITE_ACK;
            if (offset_phase_r) begin
              offset_nxt = shift_r;
              offset_phase_nxt = 1'b0;
            end else begin
              wr_stb = 1'b1;
            end
          end
        end
        HSRD_I2C_WRITE_ACK: begin
          sda_oe_nxt = 1'b0;
          bit_cnt_nxt = 4'h0;
          i2c_st_nxt = HSRD_I2C_WRITE;
        end
        HSRD_I2C_READ: begin
          if (bit_cnt_r == 4'h7) begin
            sda_oe_nxt = 1'b0;
            i2c_st_nxt = HSRD_I2C_READ_ACK;
          end else begin
            bit_cnt_nxt = bit_cnt_r + 4'h1;
            shift_nxt = {shift_r[6:0], 1'b0};
            sda_oe_nxt = ~shift_r[6];
          end
        end
        HSRD_I2C_READ_ACK: begin
          // no auto-increment: repeated reads return the same register
          shift_nxt = rd_data;
          sda_oe_nxt = ~rd_data[7];
          bit_cnt_nxt = 4'h0;
          i2c_st_nxt = HSRD_I2C_READ;
        end
        default: begin
          sda_oe_nxt = 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge clk) begin
    i2c_st_r <= i2c_st_nxt;
    bit_cnt_r <= bit_cnt_nxt;
    shift_r <= shift_nxt;
    offset_r <= offset_nxt;
    offset_phase_r <= offset_phase_nxt;
    read_dir_r <= read_dir_nxt;
    sda_oe_r <= sda_oe_nxt;
    sda_out_r <= 1'b0;
    scl_q_r <= rst_n ? scl_in : 1'b1;
    sda_q_r <= rst_n ? sda_in : 1'b1;
  end

  assign hold_req = i2c_en_r & mode_select_r[CFG_HOLD_BIT];

  hsrd_mode_fsm u_mode (
    .clk(clk),
    .rst_n(rst_n),
    .active_low_reset_in(active_low_reset_in),
    .hold_in(hold_req),
    .ls_detect_in(ls_detect_in),
    .fs_detect_in(fs_detect_in),
    .hs_detect_in(hs_detect_in),
    .fixture_detect_in(fixture_detect_in),
    .mode_r(),
    .connection_detect_r(connection_detect_out),
    .hs_active_r(hs_active_out),
    .comp_enable_r(comp_enable_out)
  );

  assign sda_out = sda_out_r;
  assign sda_oe = sda_oe_r;
  assign transition_gain_out = transition_gain_setting_r[TRANS_FIELD_HI:TRANS_FIELD_LO];
  assign static_gain_out = static_gain_setting_r[STATIC_FIELD_HI:STATIC_FIELD_LO];
  assign rx_gain_out = receive_gain_setting_r;
  assign charge_port_on_out = charge_port_r;
  assign i2c_enabled_out = i2c_en_r;

endmodule : hsrd_top

//--- verification/hsrd_top_asserts.sv
`timescale 1ns/10ps
module hsrd_top_chk (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic active_low_reset_in,
  input wire logic charge_port_enable_n,
  input wire logic ls_detect_in,
  input wire logic fs_detect_in,
  input wire logic hs_detect_in,
  input wire logic fixture_detect_in,
  input wire logic scl_in,
  input wire logic sda_in,
  input wire logic sda_out,
  input wire logic sda_oe,
  input wire logic connection_detect_out,
  input wire logic hs_active_out,
  input wire logic comp_enable_out,
  input wire logic [3:0] transition_gain_out,
  input wire logic [3:0] static_gain_out,
  input wire logic [7:0] rx_gain_out,
  input wire logic charge_port_on_out,
  input wire logic i2c_enabled_out
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);
  // the hold bit only bites once the target is on, so mode checks use this window
  logic live;
  assign live = active_low_reset_in && !i2c_enabled_out;
  a_shutdown_quiet: assert property (
    (!active_low_reset_in) [*2] |->
    !connection_detect_out && !hs_active_out && !comp_enable_out)
    else $error("indication during shutdown");
  a_low_speed: assert property (
    (live && ls_detect_in && !fs_detect_in && !hs_detect_in && !fixture_detect_in) [*4]
    |-> connection_detect_out && !hs_active_out) else $error("low speed indication");
  a_full_speed: assert property (
    (live && fs_detect_in && !hs_detect_in && !fixture_detect_in) [*4]
    |-> connection_detect_out && !hs_active_out) else $error("full speed indication");
  a_fixture_test: assert property (
    (live && fixture_detect_in) [*4] |-> !connection_detect_out && hs_active_out)
    else $error("fixture indication");
  a_comp_with_hs: assert property (
    comp_enable_out == hs_active_out) else $error("compensation out of step");
  a_charge_port: assert property (
    $past(rst_n) |-> charge_port_on_out == !$past(charge_port_enable_n))
    else $error("charge port enable wrong");
  a_open_drain: assert property (
    sda_oe |-> !sda_out) else $error("sda driven high");
  a_target_off: assert property (
    !i2c_enabled_out && !$past(i2c_enabled_out) |-> !sda_oe)
    else $error("sda pulled while disabled");
  a_enable_lines: assert property (
    $rose(i2c_enabled_out) |-> $past(scl_in && sda_in)) else $error("enabled with lines low");
  a_straps_ignored: assert property (
    live [*5] |-> $stable(transition_gain_out) && $stable(static_gain_out) &&
    $stable(rx_gain_out)) else $error("gain moved after strap window");
  c_compliance: cover property (!connection_detect_out && hs_active_out);
  c_ack: cover property ($rose(sda_oe));
  c_enabled: cover property ($rose(i2c_enabled_out));
endmodule : hsrd_top_chk
bind hsrd_top hsrd_top_chk i_chk (.clk, .rst_n, .active_low_reset_in, .charge_port_enable_n,
  .ls_detect_in, .fs_detect_in, .hs_detect_in, .fixture_detect_in, .scl_in, .sda_in,
  .sda_out, .sda_oe, .connection_detect_out, .hs_active_out, .comp_enable_out,
  .transition_gain_out, .static_gain_out, .rx_gain_out, .charge_port_on_out,
  .i2c_enabled_out);

//--- verification/hsrd_i2c_ctrl.sv
`timescale 1ns/10ps
module hsrd_i2c_ctrl #(
  parameter int QTR = 20
) (
  input wire logic clk,
  input wire logic sda_in,
  output logic scl_out,
  output logic sda_low
);
  // scl is faster than 100 khz to keep runs short; the target edge-detects per clk
  initial begin
    scl_out = 1'b1;
    sda_low = 1'b0;
  end
  task automatic qwait();
    repeat (QTR) @(negedge clk);
  endtask : qwait
  // a controller that keeps sda low across the enable sample point
  task automatic hold_sda(input logic b);
    sda_low = b;
  endtask : hold_sda
  task automatic start();
    sda_low = 1'b0;
    qwait();
    scl_out = 1'b1;
    qwait();
    sda_low = 1'b1;
    qwait();
    scl_out = 1'b0;
    qwait();
  endtask : start
  task automatic stop();
    sda_low = 1'b1;
    qwait();
    scl_out = 1'b1;
    qwait();
    sda_low = 1'b0;
    qwait();
  endtask : stop
  task automatic put_bit(input logic b, output logic got);
    sda_low = !b;
    qwait();
    scl_out = 1'b1;
    qwait();
    got = sda_in;
    qwait();
    scl_out = 1'b0;
    qwait();
  endtask : put_bit
  // msb first, ninth bit is the acknowledge
  task automatic put_byte(input logic [7:0] d, output logic [7:0] got, output logic ack);
    for (int i = 7; i >= 0; i--) put_bit(d[i], got[i]);
    put_bit(1'b1, ack);
  endtask : put_byte
  // offset first, read via repeated start, nack ends the read
  task automatic xfer(input logic [6:0] addr, input logic [7:0] ofs, input logic [7:0] wd,
                      input logic rd, output logic ok, output logic [7:0] rdata);
    logic [7:0] g;
    logic a;
    ok = 1'b1;
    start();
    put_byte({addr, 1'b0}, g, a);
    ok &= !a;
    put_byte(ofs, g, a);
    ok &= !a;
    if (rd) begin
      start();
      put_byte({addr, 1'b1}, g, a);
      ok &= !a;
      put_byte(8'hff, rdata, a);
    end else begin
      put_byte(wd, g, a);
      ok &= !a;
      rdata = g;
    end
    stop();
  endtask : xfer
endmodule : hsrd_i2c_ctrl

//--- verification/tb_hs_redriver_mode_and_config.sv
`timescale 1ns/10ps
module tb_hs_redriver_mode_and_config;
  import hsrd_pkg::*;
  localparam logic [15:0] TT = 16'ha630;
  localparam logic [15:0] ST = 16'h6220;
  localparam logic [23:0] RT = 24'h663300;
  localparam logic [15:0] DT = 16'h2481;
  localparam logic [7:0] CT = 8'he9;
  logic clk, rst_n, active_low_reset_in, charge_port_enable_n, scl_in, sda_in, sda_low;
  logic ls_detect_in, fs_detect_in, hs_detect_in, fixture_detect_in, sda_out, sda_oe;
  logic connection_detect_out, hs_active_out, comp_enable_out, charge_port_on_out;
  logic i2c_enabled_out, ok;
  logic [1:0] boost_strap_in;
  logic [3:0] transition_gain_out, static_gain_out;
  logic [7:0] rx_gain_out, r, w;
  hsrd_rx_lvl_t rx_gain_strap_pin;
  int miscompares, comparisons;
  // wired-and of both pull-downs against the bus pull-up
  assign sda_in = !(sda_low || (sda_oe && !sda_out));
  hsrd_top i_dut (.clk, .rst_n, .active_low_reset_in, .boost_strap_in, .rx_gain_strap_pin,
    .charge_port_enable_n, .ls_detect_in, .fs_detect_in, .hs_detect_in, .fixture_detect_in,
    .scl_in, .sda_in, .sda_out, .sda_oe, .connection_detect_out, .hs_active_out,
    .comp_enable_out, .transition_gain_out, .static_gain_out, .rx_gain_out,
    .charge_port_on_out, .i2c_enabled_out);
  hsrd_i2c_ctrl i_ctrl (.clk(clk), .sda_in(sda_in), .scl_out(scl_in), .sda_low(sda_low));
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  task automatic results();
    if (miscompares == 0 && comparisons > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : results
  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
    comparisons++;
    if (got !== exp) begin
      miscompares++;
      $display("mismatch at %0t: %s got %h exp %h", $time, what, got, exp);
    end
  endtask : chk
  task automatic mode_is(input logic [2:0] e);
    chk({5'h0, connection_detect_out, hs_active_out, comp_enable_out}, {5'h0, e}, "mode");
  endtask : mode_is
  task automatic set_det(input logic [3:0] d, input int n);
    {ls_detect_in, fs_detect_in, hs_detect_in, fixture_detect_in} = d;
    repeat (n) @(negedge clk);
  endtask : set_det
  task automatic pulse(input logic [1:0] b, input hsrd_rx_lvl_t x, input logic [3:0] d);
    @(negedge clk);
    active_low_reset_in = 1'b0;
    boost_strap_in = b;
    rx_gain_strap_pin = x;
    set_det(d, 4);
    mode_is(3'h0);
    active_low_reset_in = 1'b1;
    repeat (5) @(negedge clk);
  endtask : pulse
  task automatic reg_wr(input logic [7:0] ofs, input logic [7:0] d);
    i_ctrl.xfer(I2C_TARGET_ADDR, ofs, d, 1'b0, ok, w);
    chk({7'h0, ok}, 8'h01, "write ack");
  endtask : reg_wr
  task automatic reg_rd(input logic [7:0] ofs, input logic [7:0] exp);
    i_ctrl.xfer(I2C_TARGET_ADDR, ofs, 8'h00, 1'b1, ok, r);
    chk({7'h0, ok}, 8'h01, "read ack");
    chk(r, exp, "read data");
  endtask : reg_rd
  task automatic wait_en();
    int n;
    n = 0;
    while (i2c_enabled_out !== 1'b1 && n < 400) begin
      @(negedge clk);
      n++;
    end
    chk({7'h0, i2c_enabled_out}, 8'h01, "i2c enable");
    if (n == 400) results();
  endtask : wait_en
  initial begin
    rst_n = 1'b0;
    active_low_reset_in = 1'b0;
    boost_strap_in = 2'h0;
    rx_gain_strap_pin = HSRD_RX_LOW;
    charge_port_enable_n = 1'b1;
    {ls_detect_in, fs_detect_in, hs_detect_in, fixture_detect_in} = 4'h0;
    miscompares = 0;
    comparisons = 0;
    repeat (2) @(negedge clk);
    chk({3'h0, connection_detect_out, hs_active_out, comp_enable_out, sda_oe,
         i2c_enabled_out}, 8'h00, "in reset");
    rst_n = 1'b1;
    // modes fixture, low, full, high speed against boost levels 0..3
    for (int i = 0; i < 4; i++) begin
      pulse(i[1:0], hsrd_rx_lvl_t'(i % 3), DT[i*4 +: 4]);
      chk({4'h0, transition_gain_out}, {4'h0, TT[i*4 +: 4]}, "edge");
      chk({4'h0, static_gain_out}, {4'h0, ST[i*4 +: 4]}, "static");
      chk(rx_gain_out, RT[(i % 3)*8 +: 8], "rx");
      mode_is({CT[i*2 +: 2], CT[i*2]});
    end
    boost_strap_in = 2'h0;
    repeat (8) @(negedge clk);
    chk({4'h0, transition_gain_out}, 8'h0a, "strap ignored");
    pulse(2'h2, HSRD_RX_MID, 4'h2);
    mode_is(3'h3);
    set_det(4'h0, 5);
    mode_is(3'h0);
    wait_en();
    reg_rd(OFS_TRANSITION, 8'h60);
    reg_rd(OFS_STATIC, 8'h02);
    reg_rd(OFS_RECEIVE, 8'h33);
    reg_rd(8'h10, 8'h00);
    i_ctrl.xfer(7'h2d, OFS_MODE_SELECT, 8'h00, 1'b1, ok, r);
    chk({7'h0, ok}, 8'h00, "foreign address");
    set_det(4'h8, 5);
    mode_is(3'h0);
    reg_rd(OFS_MODE_SELECT, 8'h01);
    reg_wr(OFS_MODE_SELECT, {r[7:1], 1'b0});
    repeat (5) @(negedge clk);
    mode_is(3'h4);
    reg_rd(OFS_TRANSITION, 8'h60);
    reg_wr(OFS_TRANSITION, {4'hf, r[3:0]});
    reg_rd(OFS_TRANSITION, 8'hf0);
    chk({4'h0, transition_gain_out}, 8'h0f, "edge out");
    reg_rd(OFS_STATIC, 8'h02);
    reg_wr(OFS_STATIC, {r[7:4], 4'hf});
    chk({4'h0, static_gain_out}, 8'h0f, "static out");
    reg_wr(OFS_RECEIVE, 8'hff);
    chk(rx_gain_out, 8'hff, "rx out");
    reg_wr(OFS_MODE_SELECT, 8'h01);
    set_det(4'h0, 5);
    mode_is(3'h4);
    charge_port_enable_n = 1'b0;
    repeat (2) @(negedge clk);
    chk({7'h0, charge_port_on_out}, 8'h01, "charge on");
    charge_port_enable_n = 1'b1;
    repeat (2) @(negedge clk);
    chk({7'h0, charge_port_on_out}, 8'h00, "charge off");
    i_ctrl.hold_sda(1'b1);
    pulse(2'h0, HSRD_RX_LOW, 4'h0);
    repeat (210) @(negedge clk);
    chk({7'h0, i2c_enabled_out}, 8'h00, "i2c stays off");
    results();
  end
endmodule : tb_hs_redriver_mode_and_config
